// ### core/double_word_32bit_shift_rotate_unit.sv
// top of the double-word shift and rotate unit
// assumes operation select is static and inputs are synchronous to core_clk
`timescale 1ns/1ns
module dsr_double_word_32bit_shift_rotate_unit
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic enableIn,
   input wire dsr_pkg::dsr_op_t opSel,
   input wire logic [dsr_pkg::DATA_W-1:0] operandIn,
   input wire logic [dsr_pkg::CNT_W-1:0] shiftCount,
   output logic enableFollowOut,
   output logic [dsr_pkg::DATA_W-1:0] resultOut,
   output logic conditionCodeBit0,
   output logic overflowFlag
);
   import dsr_pkg::*;

   dsr_state_t stateFf;
   dsr_state_t nxtState;
   logic [AMT_W-1:0] amount;
   logic [DATA_W-1:0] shifted;
   logic shrSel;
   logic rotSel;
   logic cntZero;
   logic cntOver;

   function automatic logic isShiftRight(input dsr_op_t op);
      isShiftRight = (op == DSR_OP_SHR);
   endfunction

   function automatic logic isRotate(input dsr_op_t op);
      case (op)
         DSR_OP_ROL:
            isRotate = 1'b1;
         DSR_OP_ROR:
            isRotate = 1'b1;
         default:
            isRotate = 1'b0;
      endcase
   endfunction

   function automatic logic isZero(input logic [CNT_W-1:0] cnt);
      isZero = (cnt == CNT_ZERO);
   endfunction

   function automatic logic isOverRange(input logic [CNT_W-1:0] cnt);
      isOverRange = (cnt > CNT_LIMIT);
   endfunction

   // counts above the limit wrap for rotates and saturate for the shift
   function automatic logic [AMT_W-1:0] reduceCount(input logic [CNT_W-1:0] cnt,
      input logic isRot);
      logic [CNT_W-1:0] cntLess;
      logic [ROT_W-1:0] wrapped;
      cntLess = cnt - CNT_ONE;
      wrapped = cntLess[ROT_W-1:0] & ROT_MASK;
      if (!isOverRange(cnt))
         reduceCount = cnt[AMT_W-1:0];
      else if (isRot)
         reduceCount = {1'b0, wrapped} + AMT_ONE;
      else
         reduceCount = CNT_LIMIT[AMT_W-1:0];
   endfunction

   always_comb
   begin
      shrSel = isShiftRight(opSel);
      rotSel = isRotate(opSel);
      cntZero = isZero(shiftCount);
      cntOver = isOverRange(shiftCount);
      amount = reduceCount(shiftCount, rotSel);
   end

   dsr_barrel uBarrel
   (
      .operand(operandIn),
      .amount(amount),
      .opSel(opSel),
      .shifted(shifted)
   );

   always_comb
   begin
      nxtState = stateFf;
      if (enableIn)
      begin
         if (cntZero)
         begin
            nxtState.result = operandIn;
         end
         else if (shrSel && cntOver)
         begin
            nxtState.result = RESULT_ZERO;
            nxtState.cc0 = FLAG_CLEAR;
            nxtState.ovf = FLAG_CLEAR;
         end
         else
         begin
            nxtState.result = shifted;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         stateFf.result <= RESULT_RST;
         stateFf.cc0 <= FLAG_RST;
         stateFf.ovf <= FLAG_RST;
      end
      else if (clkEn)
      begin
         stateFf <= nxtState;
      end
   end

   assign enableFollowOut = enableIn;
   assign resultOut = stateFf.result;
   assign conditionCodeBit0 = stateFf.cc0;
   assign overflowFlag = stateFf.ovf;
endmodule

// ### core/dsr_barrel.sv
// combinational barrel for shift right and both rotates
// assumes the amount is already reduced to 0..32
`timescale 1ns/1ns
module dsr_barrel
(
   input wire logic [dsr_pkg::DATA_W-1:0] operand,
   input wire logic [dsr_pkg::AMT_W-1:0] amount,
   input wire dsr_pkg::dsr_op_t opSel,
   output logic [dsr_pkg::DATA_W-1:0] shifted
);
   import dsr_pkg::*;
   logic [2*DATA_W-1:0] dbl;
   logic [2*DATA_W-1:0] ext;
   always_comb
   begin
      dbl = {operand, operand};
      ext = '0;
      shifted = operand;
      case (opSel)
         DSR_OP_SHR:
         begin
            ext = {{DATA_W{1'b0}}, operand} >> amount;
            shifted = ext[DATA_W-1:0];
         end
         DSR_OP_ROL:
         begin
            ext = dbl << amount;
            shifted = ext[2*DATA_W-1:DATA_W];
         end
         DSR_OP_ROR:
         begin
            ext = dbl >> amount;
            shifted = ext[DATA_W-1:0];
         end
         default:
            shifted = operand;
      endcase
   end
endmodule

// ### core/dsr_pkg.sv
// constants and types for the double-word shift and rotate unit
// assumes one clock domain with synchronous active-low reset
// Overview of operation
// - right shift moves operand toward bit zero
// - right shift count over 32 gives zero, flags cleared
// - right shift fills vacated high bits with zero
// - enable output follows enable input
// - result held in clocked storage between evaluations
// - rotate left moves operand toward bit 31
// - rotate count over 32 wraps as ((n-1) mod 32)+1
// - rotate left refills low bits from high end
// - rotate right refills high bits from low end
// - operand and result 32 bits, count 16 bits
package dsr_pkg;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_LIMIT = 16'h0020;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [4:0] ROT_MASK = 5'h1f;
   localparam int AMT_W = 6;
   localparam int ROT_W = 5;
   localparam logic [5:0] AMT_ONE = 6'h01;
   localparam logic [31:0] RESULT_RST = 32'h0000_0000;
   localparam logic [31:0] RESULT_ZERO = 32'h0000_0000;
   localparam logic FLAG_RST = 1'b0;
   localparam logic FLAG_CLEAR = 1'b0;

   typedef enum logic [2:0]
   {
      DSR_OP_SHR = 3'b001,
      DSR_OP_ROL = 3'b010,
      DSR_OP_ROR = 3'b100
   } dsr_op_t;

   typedef struct packed
   {
      logic [31:0] result;
      logic cc0;
      logic ovf;
   } dsr_state_t;
endpackage

// ### verif/double_word_32bit_shift_rotate_unit_test.sv
// bench for the shift and rotate unit
// assumes the checker is bound to the unit
`timescale 1ns/1ns
module double_word_32bit_shift_rotate_unit_test;
   import dsr_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, enableIn = 1'b0, efo, cc0, ovf;
   logic [31:0] opnd = 32'h0, res;
   logic [15:0] cnt = 16'h0;
   dsr_op_t opReq = DSR_OP_SHR, opSel;
   int miscompares = 0, checks = 0;
   dsr_net_model net (.opReq(opReq), .opSel(opSel));
   dsr_double_word_32bit_shift_rotate_unit dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
      .enableIn(enableIn), .opSel(opSel), .operandIn(opnd), .shiftCount(cnt),
      .enableFollowOut(efo), .resultOut(res), .conditionCodeBit0(cc0), .overflowFlag(ovf));
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task run(input dsr_op_t op, input logic [31:0] v, input logic [15:0] n, input logic [31:0] e);
      @(negedge core_clk);
      opReq = op;
      opnd = v;
      cnt = n;
      enableIn = 1'b1;
      @(negedge core_clk);
      cmp(res, e);
      cmp({cc0, ovf, efo}, 32'h1);
   endtask
   task t_shr;
      run(DSR_OP_SHR, 32'h8000_0001, 16'h0001, 32'h4000_0000);
      run(DSR_OP_SHR, 32'h8000_0001, 16'h001f, 32'h0000_0001);
      run(DSR_OP_SHR, 32'hffff_ffff, 16'h0020, 32'h0);
      run(DSR_OP_SHR, 32'hffff_ffff, 16'h0021, 32'h0);
      run(DSR_OP_SHR, 32'h1234_5678, 16'h0000, 32'h1234_5678);
   endtask
   task t_rot;
      run(DSR_OP_ROL, 32'h8000_0001, 16'h0001, 32'h0000_0003);
      run(DSR_OP_ROL, 32'h8000_0001, 16'h0021, 32'h0000_0003);
      run(DSR_OP_ROR, 32'h8000_0003, 16'h0001, 32'hc000_0001);
      run(DSR_OP_ROR, 32'h8000_0003, 16'h0020, 32'h8000_0003);
      run(DSR_OP_ROR, 32'h8000_0003, 16'hffff, 32'h0000_0007);
   endtask
   task t_hold;
      {enableIn, opnd} = {1'b0, 32'hffff_ffff};
      @(negedge core_clk);
      cmp(res, 32'h0000_0007);
      cmp({31'h0000_0000, efo}, 32'h0000_0000);
      {clkEn, enableIn} = 2'b01;
      @(negedge core_clk);
      cmp(res, 32'h0000_0007);
      {clkEn, rst_n} = 2'b10;
      @(negedge core_clk);
      cmp(res, 32'h0);
   endtask
   task print_verdict;
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial forever #10 core_clk = ~core_clk;
   initial
   begin
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      t_shr;
      t_rot;
      t_hold;
      print_verdict;
   end
   initial
   begin
      #20000;
      miscompares++;
      print_verdict;
   end
endmodule

// ### verif/dsr_net_model.sv
// partner model: surrounding network that selects the operation
// assumes the request is steady while a test uses it
`timescale 1ns/1ns
module dsr_net_model
(
   input wire dsr_pkg::dsr_op_t opReq,
   output dsr_pkg::dsr_op_t opSel
);
   assign opSel = opReq;
endmodule

// ### verif/dsr_sru_assertions.sv
// checker for the shift and rotate unit
// assumes the unit's top ports only
`timescale 1ns/1ns
module dsr_sru_assertions
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic enableIn,
   input wire dsr_pkg::dsr_op_t opSel,
   input wire logic [31:0] operandIn,
   input wire logic [15:0] shiftCount,
   input wire logic enableFollowOut,
   input wire logic [31:0] resultOut,
   input wire logic conditionCodeBit0,
   input wire logic overflowFlag
);
   import dsr_pkg::*;
   logic go;
   logic [63:0] dbl;
   assign go = clkEn && enableIn;
   assign dbl = {operandIn, operandIn};
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   follow_en_a: assert property (enableFollowOut == enableIn) else $error("follow");
   shr_val_a: assert property (go && opSel == DSR_OP_SHR
      && shiftCount <= 16'h0020 |=> resultOut == ($past(operandIn) >> $past(shiftCount)))
      else $error("shr");
   shr_over_a: assert property (go && opSel == DSR_OP_SHR && shiftCount > 16'h0020 |=>
      resultOut == 32'h0 && !conditionCodeBit0 && !overflowFlag) else $error("over");
   rol_val_a: assert property (go && opSel == DSR_OP_ROL |=>
      resultOut == $past(dbl[63 - shiftCount[4:0] -: 32])) else $error("rol");
   ror_val_a: assert property (go && opSel == DSR_OP_ROR |=>
      resultOut == $past(dbl[31 + shiftCount[4:0] -: 32])) else $error("ror");
   hold_idle_a: assert property (!go |=> $stable(resultOut)) else $error("hold");
   zero_pass_a: assert property (go && shiftCount == 16'h0 |=>
      resultOut == $past(operandIn)) else $error("zero");
   flag_keep_a: assert property (!(go && opSel == DSR_OP_SHR && shiftCount > 16'h0020) |=>
      $stable({conditionCodeBit0, overflowFlag})) else $error("flag");
endmodule
bind dsr_double_word_32bit_shift_rotate_unit dsr_sru_assertions chk (.*);
